/* src/scs_top.sv */
// Clock-stop serial port with its transmit FIFO and an Avalon-MM register slave.
// Overview of operation
// [R01] Generated bit clock period equals divide value plus one, in CPU cycles.
// [R02] Low phase is half period for odd divide, else divide/2 cycles.
// [R03] High phase is half period for odd divide, else divide/2 plus one cycles.
// [R04] Slave mode forces source select and divide value to one.
// [R05] Sync polarities read as one; master drives inverted, active-low slave enable.
// [R06] Slave inverts the active-low enables received on both sync pins.
// [R07] Master drives bit clock and transmit sync; receive side pins are inputs.
// [R08] Slave drives neither clock nor sync; all four directions are inputs.
// [R09] Slave enable falls before the first rising clock edge of a transfer.
// [R10] Codes 11b/pol0 and 10b/pol1 launch transmit bits on falling clock edges.
// [R11] Code 10b with polarity one captures receive data on rising edges.
// [R12] Code 11b with polarity zero captures receive data on falling edges.
// [R13] Master 11b/pol0 lowers enable one full period before the first edge.
// [R14] Master 10b/pol1 lowers enable one high phase before the first edge.
// [R15] Master 11b/pol0 holds enable one low phase after the last edge.
// [R16] Master 10b/pol1 holds enable one full period after the last edge.
// [R17] Slave releases its data output shortly after the enable is deasserted.
// [R18] Slave drives its first data bit only some cycles after enable falls.
// [R19] Master bit clock idles at the polarity level outside a transfer.
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns

module scs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           rd;
        logic [AW-1:0]           wr;
        logic [CW-1:0]           count;
    } scs_fifo_s;

    scs_fifo_s q;
    scs_fifo_s n;
    logic      push;
    logic      pop;

    assign in_ready  = (q.count != FULL);
    assign out_valid = (q.count != '0);
    assign out_data  = q.mem[q.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        n = q;
        if (push) begin
            n.mem[q.wr] = in_data;
            n.wr        = (q.wr == LAST) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            n.rd = (q.rd == LAST) ? '0 : q.rd + 1'b1;
        end
        n.count = q.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end
endmodule

module scs_top (
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    input  wire scs_pkg::scs_av_req_s   av_req,
    output scs_pkg::scs_av_rsp_s        av_rsp,
    input  wire scs_pkg::scs_pins_in_s  pins_in,
    output scs_pkg::scs_pins_out_s      pins_out
);
    import scs_pkg::*;

    typedef struct packed {
        scs_ctrl_s     ctrl;
        logic          rxv;
        logic          ovr;
        logic [WORD-1:0] rxd;
        scs_av_rsp_s   rsp;
        scs_pins_out_s po;
        scs_state_e    st;
        logic [8:0]    cnt;
        logic [4:0]    edges;
        logic [3:0]    shifts;
        logic [WORD-1:0] tsh;
        logic [WORD-1:0] rsh;
        logic          sclk_q;
        logic          act_q;
        logic [1:0]    dly;
    } scs_state_s;

    scs_state_s      q;
    scs_state_s      n;
    logic            bus_push;
    logic            fifo_pop;
    logic            fifo_in_ready;
    logic            fifo_out_valid;
    logic [WORD-1:0] fifo_out_data;
    logic [7:0]      div_e;
    logic [7:0]      eff_div;
    logic [8:0]      period;
    logic [8:0]      lo;
    logic [8:0]      hi;
    logic [8:0]      lead;
    logic [8:0]      trail;
    logic            launch_fall;
    logic            capture_rise;
    logic            act;
    logic            do_edge;
    logic            nl;
    logic            rx_push;
    logic [31:0]     stat;

    assign av_rsp   = q.rsp;
    assign pins_out = q.po;

    scs_fifo #(
        .W     (WORD),
        .DEPTH (FIFO_DEPTH)
    ) u_txfifo (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (bus_push),
        .in_ready  (fifo_in_ready),
        .in_data   (av_req.writedata[WORD-1:0]),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // A zero divide would need half-cycle phases, so it runs as a divide of one.
    always_comb begin
        div_e        = (q.ctrl.div == DIV_ZERO) ? SLAVE_DIV : q.ctrl.div;
        eff_div      = q.ctrl.master ? div_e : SLAVE_DIV; // [R04]
        period       = {1'b0, div_e} + 9'h1; // [R01]
        lo           = div_e[0] ? (period >> 1) : {2'b0, div_e[7:1]}; // [R02]
        hi           = div_e[0] ? (period >> 1) : {2'b0, div_e[7:1]} + 9'h1; // [R03]
        lead         = q.ctrl.stop[0] ? period : (q.ctrl.pol ? hi : lo); // [R13] [R14]
        trail        = q.ctrl.stop[0] ? (q.ctrl.pol ? hi : lo) : period; // [R15] [R16]
        launch_fall  = q.ctrl.stop[0] ^ q.ctrl.pol; // [R10]
        capture_rise = (q.ctrl.stop == STOP_NO_DELAY) && q.ctrl.pol; // [R11] [R12]
        act          = ~pins_in.fsx; // [R06]
        stat                = '0;
        stat[ST_BUSY]       = (q.st != ST_IDLE);
        stat[ST_TXFULL]     = ~fifo_in_ready;
        stat[ST_TXEMPTY]    = ~fifo_out_valid;
        stat[ST_RXVALID]    = q.rxv;
        stat[ST_OVERRUN]    = q.ovr;
        stat[ST_TXCLKDIR]   = q.ctrl.master; // [R07] [R08]
        stat[ST_TXFSDIR]    = q.ctrl.master;
        stat[ST_RXCLKDIR]   = 1'b0;
        stat[ST_RXFSDIR]    = 1'b0;
        stat[ST_RXFSPOL]    = 1'b1; // [R05]
        stat[ST_TXFSPOL]    = 1'b1;
        stat[ST_SRCSEL]     = q.ctrl.master ? q.ctrl.src : 1'b1; // [R04]
        stat[ST_DIV_LSB +: 8] = eff_div;
    end

    always_comb begin
        n        = q;
        bus_push = 1'b0;
        fifo_pop = 1'b0;
        do_edge  = 1'b0;
        nl       = 1'b0;
        rx_push  = 1'b0;
        // Bus: a TX write waits while the FIFO is full, which stalls the master.
        if (!q.rsp.waitrequest) begin
            n.rsp.waitrequest = 1'b1;
        end else if ((av_req.read || av_req.write)
                     && !(av_req.write && av_req.address == TXD_OFS && !fifo_in_ready)) begin
            n.rsp.waitrequest = 1'b0;
            n.rsp.readdata    = '0;
            if (av_req.write) begin
                case (av_req.address)
                    CTRL_OFS: begin
                        if (q.st == ST_IDLE) begin
                            n.ctrl     = scs_ctrl_s'(av_req.writedata[CTRL_W-1:0]);
                            n.ctrl.rsv = '0;
                        end
                    end
                    STAT_OFS: begin
                        if (av_req.writedata[ST_OVERRUN]) begin
                            n.ovr = 1'b0;
                        end
                    end
                    TXD_OFS:  bus_push = 1'b1;
                    default:  ;
                endcase
            end else begin
                case (av_req.address)
                    CTRL_OFS: n.rsp.readdata = {16'h0, q.ctrl};
                    STAT_OFS: n.rsp.readdata = stat;
                    RXD_OFS: begin
                        n.rsp.readdata = {24'h0, q.rxd};
                        n.rxv          = 1'b0;
                    end
                    default:  n.rsp.readdata = '0;
                endcase
            end
        end
        if (q.ctrl.master) begin
            n.po.sclk_oe = q.ctrl.en; // [R07]
            n.po.fsx_oe  = q.ctrl.en;
            unique case (q.st)
                ST_IDLE: begin
                    n.po.sclk_o = q.ctrl.pol; // [R19]
                    n.po.fsx_o  = 1'b1;
                    if (q.ctrl.en && fifo_out_valid) begin
                        fifo_pop     = 1'b1;
                        n.tsh        = fifo_out_data;
                        n.st         = ST_LEAD;
                        n.po.fsx_o   = 1'b0; // [R05] [R09]
                        n.po.dout_oe = 1'b1;
                        n.cnt        = lead - 9'h1;
                        n.edges      = '0;
                        n.shifts     = '0;
                    end
                end
                ST_LEAD, ST_RUN: begin
                    if (q.cnt == '0) begin
                        do_edge = 1'b1;
                        nl      = ~q.po.sclk_o;
                    end else begin
                        n.cnt = q.cnt - 9'h1;
                    end
                end
                ST_TRAIL: begin
                    if (q.cnt == '0) begin
                        n.po.fsx_o   = 1'b1;
                        n.po.dout_oe = 1'b0;
                        n.st         = ST_IDLE;
                        rx_push      = 1'b1;
                    end else begin
                        n.cnt = q.cnt - 9'h1;
                    end
                end
            endcase
        end else begin
            n.po.sclk_oe = 1'b0; // [R08]
            n.po.fsx_oe  = 1'b0;
            n.po.fsx_o   = 1'b1;
            n.po.sclk_o  = q.ctrl.pol;
            n.sclk_q     = pins_in.sclk;
            n.act_q      = act;
            unique case (q.st)
                ST_IDLE: begin
                    if (q.ctrl.en && act && !q.act_q) begin
                        fifo_pop = fifo_out_valid;
                        n.tsh    = fifo_out_valid ? fifo_out_data : '0;
                        n.st     = ST_RUN;
                        n.dly    = SLV_DRIVE_LD;
                        n.edges  = '0;
                        n.shifts = '0;
                    end
                end
                ST_RUN: begin
                    if (!act) begin
                        n.st    = ST_TRAIL;
                        n.dly   = SLV_RELEASE_LD;
                        rx_push = (q.edges == EDGES_FULL);
                    end else begin
                        if (q.dly != '0) begin
                            n.dly = q.dly - 2'h1;
                        end else begin
                            n.po.dout_oe = 1'b1; // [R18]
                        end
                        if (pins_in.sclk != q.sclk_q) begin
                            do_edge = 1'b1;
                            nl      = pins_in.sclk;
                        end
                    end
                end
                ST_LEAD, ST_TRAIL: begin
                    if (q.dly == '0) begin
                        n.po.dout_oe = 1'b0; // [R17]
                        n.st         = ST_IDLE;
                    end else begin
                        n.dly = q.dly - 2'h1;
                    end
                end
            endcase
        end
        if (do_edge) begin
            if (nl != launch_fall && q.edges != '0 && q.shifts != SHIFT_MAX) begin
                n.tsh    = {q.tsh[WORD-2:0], 1'b0}; // [R10]
                n.shifts = q.shifts + 4'h1;
            end
            if (nl == capture_rise && (q.ctrl.master || !pins_in.fsr)) begin
                n.rsh = {q.rsh[WORD-2:0], pins_in.din}; // [R11] [R12] [R06]
            end
            if (q.edges != EDGES_FULL) begin
                n.edges = q.edges + 5'h1;
            end
            if (q.ctrl.master) begin
                n.po.sclk_o = nl;
                n.st        = ST_RUN;
                n.cnt       = (nl ? hi : lo) - 9'h1; // [R02] [R03]
                if (q.edges == LAST_EDGE) begin
                    n.st  = ST_TRAIL;
                    n.cnt = trail - 9'h1; // [R15] [R16]
                end
            end
        end
        // The new word is applied after the bus read so an arrival beats the clear.
        if (rx_push) begin
            n.ovr = n.ovr | n.rxv;
            n.rxv = 1'b1;
            n.rxd = q.rsh;
        end
        n.po.dout = n.tsh[WORD-1];
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q          <= '0;
            q.ctrl     <= CTRL_RST;
            q.rsp      <= '{readdata: '0, waitrequest: 1'b1};
            q.po.fsx_o <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // Helper counters for the assertions: cycles each level of clock and enable has stood.
    logic [8:0] hc;
    logic [8:0] phc;
    logic [8:0] fc;
    logic       mas_en;
    logic       slv_en;

    assign mas_en = q.ctrl.en && q.ctrl.master;
    assign slv_en = q.ctrl.en && !q.ctrl.master;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hc  <= '0;
            phc <= '0;
            fc  <= '0;
        end else begin
            hc  <= (n.po.sclk_o != q.po.sclk_o) ? 9'h1 : hc + 9'h1;
            phc <= (n.po.sclk_o != q.po.sclk_o) ? hc : phc;
            fc  <= (n.po.fsx_o != q.po.fsx_o) ? 9'h1 : fc + 9'h1;
        end
    end

    a_low_phase: assert property (@(posedge clk_sys) disable iff (!nrst) // [R02]
        (mas_en && q.st == ST_RUN && q.cnt == '0 && !q.po.sclk_o) |-> hc == lo)
        else $error("bit clock low phase has the wrong length");
    a_high_phase: assert property (@(posedge clk_sys) disable iff (!nrst) // [R03]
        (mas_en && q.st == ST_RUN && q.cnt == '0 && q.po.sclk_o) |-> hc == hi)
        else $error("bit clock high phase has the wrong length");
    a_clock_period: assert property (@(posedge clk_sys) disable iff (!nrst) // [R01]
        (mas_en && q.st == ST_RUN && q.cnt == '0 && q.edges >= 5'h2)
        |-> ({1'b0, hc} + {1'b0, phc}) == {1'b0, period})
        else $error("bit clock period differs from divide plus one");
    a_lead_time: assert property (@(posedge clk_sys) disable iff (!nrst) // [R13]
        (mas_en && q.st == ST_LEAD && q.cnt == '0) |-> !q.po.fsx_o && fc == lead)
        else $error("slave enable lead before first edge is wrong");
    a_trail_time: assert property (@(posedge clk_sys) disable iff (!nrst) // [R15]
        (mas_en && q.st == ST_TRAIL && q.cnt == '0) |-> hc == trail ##1 q.po.fsx_o)
        else $error("slave enable hold after last edge is wrong");
    a_enable_low: assert property (@(posedge clk_sys) disable iff (!nrst) // [R05]
        (mas_en && q.st != ST_IDLE) |-> !q.po.fsx_o && q.po.dout_oe)
        else $error("slave enable not low during master transfer");
    a_idle_level: assert property (@(posedge clk_sys) disable iff (!nrst) // [R19]
        (q.ctrl.master && q.st == ST_IDLE && $past(q.st) == ST_IDLE && $stable(q.ctrl))
        |-> q.po.sclk_o == q.ctrl.pol)
        else $error("idle bit clock not at polarity level");
    a_master_dirs: assert property (@(posedge clk_sys) disable iff (!nrst) // [R07]
        (mas_en && $past(mas_en)) |-> q.po.sclk_oe && q.po.fsx_oe)
        else $error("master does not drive clock and sync");
    a_slave_dirs: assert property (@(posedge clk_sys) disable iff (!nrst) // [R08]
        (!q.ctrl.master && $past(q.ctrl.master) == 1'b0) |-> !q.po.sclk_oe && !q.po.fsx_oe)
        else $error("slave drives clock or sync");
    a_launch_fall: assert property (@(posedge clk_sys) disable iff (!nrst) // [R10]
        (mas_en && launch_fall && $past(q.st) == ST_RUN && $changed(q.tsh))
        |-> !q.po.sclk_o && $past(q.po.sclk_o))
        else $error("transmit bit launched off the falling edge");
    a_slave_drive: assert property (@(posedge clk_sys) disable iff (!nrst) // [R18]
        (slv_en && q.st == ST_IDLE && act && !q.act_q)
        |-> ##1 !q.po.dout_oe ##1 !q.po.dout_oe ##1 !q.po.dout_oe)
        else $error("slave drove data too soon after enable");
    a_slave_release: assert property (@(posedge clk_sys) disable iff (!nrst) // [R17]
        (slv_en && q.st == ST_RUN && !act) |-> ##[2:3] !q.po.dout_oe)
        else $error("slave did not release data after enable ended");
endmodule

/* pkg/scs_pkg.sv */
// Package for the clock-stop serial port: register map, field layouts, timing and carriers.
package scs_pkg;

    localparam int          WORD       = 8;
    localparam int          FIFO_DEPTH = 8;
    localparam int          CTRL_W     = 16;

    localparam logic [4:0]  CTRL_OFS   = 5'h00;
    localparam logic [4:0]  STAT_OFS   = 5'h04;
    localparam logic [4:0]  TXD_OFS    = 5'h08;
    localparam logic [4:0]  RXD_OFS    = 5'h0c;

    localparam int          ST_BUSY     = 0;
    localparam int          ST_TXFULL   = 1;
    localparam int          ST_TXEMPTY  = 2;
    localparam int          ST_RXVALID  = 3;
    localparam int          ST_OVERRUN  = 4;
    localparam int          ST_TXCLKDIR = 8;
    localparam int          ST_TXFSDIR  = 9;
    localparam int          ST_RXCLKDIR = 10;
    localparam int          ST_RXFSDIR  = 11;
    localparam int          ST_RXFSPOL  = 12;
    localparam int          ST_TXFSPOL  = 13;
    localparam int          ST_SRCSEL   = 14;
    localparam int          ST_DIV_LSB  = 16;

    localparam logic [1:0]  STOP_NO_DELAY   = 2'h2;
    localparam logic [1:0]  STOP_HALF_DELAY = 2'h3;
    localparam logic [7:0]  SLAVE_DIV       = 8'h01;
    localparam logic [7:0]  DIV_ZERO        = 8'h00;

    localparam int          CLK_NS          = 10;
    localparam int          SLV_DRIVE_NS    = 22;
    localparam int          SLV_RELEASE_NS  = 13;
    localparam int          SLV_DRIVE_CYC   = (SLV_DRIVE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          SLV_RELEASE_CYC = (SLV_RELEASE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0]  SLV_DRIVE_LD    = 2'(SLV_DRIVE_CYC - 1);
    localparam logic [1:0]  SLV_RELEASE_LD  = 2'(SLV_RELEASE_CYC - 1);

    localparam logic [4:0]  LAST_EDGE  = 5'(2 * WORD - 1);
    localparam logic [4:0]  EDGES_FULL = 5'(2 * WORD);
    localparam logic [3:0]  SHIFT_MAX  = 4'(WORD - 1);

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_RUN   = 2'b10,
        ST_TRAIL = 2'b11
    } scs_state_e;

    typedef struct packed {
        logic [7:0] div;
        logic [1:0] rsv;
        logic       src;
        logic       pol;
        logic [1:0] stop;
        logic       master;
        logic       en;
    } scs_ctrl_s;

    localparam scs_ctrl_s CTRL_RST = '{div: 8'h01, default: '0};

    typedef struct packed {
        logic [4:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } scs_av_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } scs_av_rsp_s;

    typedef struct packed {
        logic sclk;
        logic fsx;
        logic fsr;
        logic din;
    } scs_pins_in_s;

    typedef struct packed {
        logic sclk_o;
        logic sclk_oe;
        logic fsx_o;
        logic fsx_oe;
        logic dout;
        logic dout_oe;
    } scs_pins_out_s;

endpackage

/* testbench/scs_spi_model.sv */
// Behavioural SPI slave standing on the far side of the serial port in master mode.
`timescale 1ns/1ns

module scs_spi_model (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       sclk,
    input  wire logic       sel_n,
    input  wire logic       mosi,
    input  wire logic       cap_rise,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic       sclk_q;
    logic       sel_q;
    logic [7:0] sh;

    // Released data line has no pull, so it toggles rather than holding its last bit.
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sclk_q  <= 1'b0;
            sel_q   <= 1'b1;
            sh      <= 8'h00;
            miso    <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            sclk_q <= sclk;
            sel_q  <= sel_n;
            if (sel_q && !sel_n) begin
                sh   <= tx_byte;
                miso <= tx_byte[7];
            end else if (sel_n) begin
                miso <= ~miso;
            end else if (sclk != sclk_q && sclk == cap_rise) begin
                sh   <= {sh[6:0], 1'b0};
                miso <= sh[6];
            end
            if (!sel_n && sclk && !sclk_q) begin
                rx_byte <= {rx_byte[6:0], mosi};
            end
        end
    end
endmodule

/* testbench/tb_top.sv */
// Self-checking testbench for the clock-stop serial port.
`timescale 1ns/1ns

module tb_top;
    import scs_pkg::*;
    logic          clk_sys = 1'b0;
    logic          nrst    = 1'b0;
    scs_av_req_s   req     = '0;
    scs_av_rsp_s   rsp;
    scs_pins_in_s  pin;
    scs_pins_out_s po;
    logic          t_sclk  = 1'b0;
    logic          t_fsx   = 1'b1;
    logic          t_din   = 1'b0;
    logic          cap_rise = 1'b0;
    logic          miso;
    logic [7:0]    p_tx    = 8'h00;
    logic [7:0]    p_rx;
    logic [31:0]   rd;
    logic          fq      = 1'b1;
    logic          sq      = 1'b0;
    int            n_mismatch = 0, n_compared = 0, cyc = 0, tg = 0;
    int            t_fall = 0, t_rise = 0, last = 0;
    int            tt[3];

    always #5 clk_sys = ~clk_sys;
    assign pin.sclk = po.sclk_oe ? po.sclk_o : t_sclk;
    assign pin.fsx  = po.fsx_oe ? po.fsx_o : t_fsx;
    assign pin.fsr  = pin.fsx;
    assign pin.din  = po.sclk_oe ? miso : t_din;

    scs_top i_scs_top (.clk_sys(clk_sys), .nrst(nrst), .av_req(req), .av_rsp(rsp),
                       .pins_in(pin), .pins_out(po));
    scs_spi_model i_scs_spi_model (.clk_sys(clk_sys), .nrst(nrst), .sclk(pin.sclk),
                                   .sel_n(pin.fsx), .mosi(po.dout), .cap_rise(cap_rise),
                                   .tx_byte(p_tx), .miso(miso), .rx_byte(p_rx));

    // Pin monitor samples just after each edge so registered outputs have settled.
    always @(posedge clk_sys) begin
        #1;
        cyc++;
        if (fq && !pin.fsx) begin
            t_fall = cyc;
            tg = 0;
        end
        if (!pin.fsx && pin.sclk !== sq) begin
            if (tg < 3) tt[tg] = cyc;
            tg++;
            last = cyc;
        end
        if (!fq && pin.fsx) t_rise = cyc;
        fq = pin.fsx;
        sq = pin.sclk;
        if (cyc > 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude;
        $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{address: a, read: !wr, write: wr, writedata: d};
        do @(posedge clk_sys); while (rsp.waitrequest !== 1'b0);
        rd = rsp.readdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic frame(input logic [1:0] code, input logic pol, input logic [7:0] div,
                         input logic [7:0] d, input logic [7:0] pd);
        int t, c, h;
        t = div + 1;
        c = div[0] ? t / 2 : div / 2;
        h = div[0] ? t / 2 : div / 2 + 1;
        cap_rise <= (code == 2'b10) && pol;
        p_tx <= pd;
        bus(1'b1, CTRL_OFS, {16'h0, div, 3'b000, pol, code, 2'b11});
        bus(1'b0, STAT_OFS, 32'h0);
        chk(rd, {8'h00, div, 16'h3304});
        chk(po.sclk_o, pol);
        chk({po.sclk_oe, po.fsx_oe, po.fsx_o}, 3'b111);
        bus(1'b1, TXD_OFS, {24'h0, d});
        repeat (3) @(posedge clk_sys);
        for (int k = 0; k < 400 && t_rise <= t_fall; k++) @(posedge clk_sys);
        chk(t_rise > t_fall, 1'b1);
        chk(tg, 16);
        chk(tt[0] - t_fall, code[0] ? t : (pol ? h : c));
        chk(tt[1] - tt[0], pol ? c : h);
        chk(tt[2] - tt[1], pol ? h : c);
        chk(t_rise - last, code[0] ? (pol ? h : c) : t);
        chk(p_rx, d);
        bus(1'b0, RXD_OFS, 32'h0);
        chk(rd[7:0], pd);
        $display("Master frame code %b polarity %b divide %0d done", code, pol, div);
    endtask

    task automatic fill_drain;
        bus(1'b1, CTRL_OFS, 32'h0000_010e);
        for (int i = 0; i < 8; i++) bus(1'b1, TXD_OFS, 32'(i + 8'h30));
        bus(1'b0, STAT_OFS, 32'h0);
        chk(rd[2:0], 3'b010);
        bus(1'b1, CTRL_OFS, 32'h0000_010f);
        repeat (400) @(posedge clk_sys);
        bus(1'b0, STAT_OFS, 32'h0);
        chk(rd[4:0], 5'b11100);
        chk(p_rx, 8'h37);
        bus(1'b0, RXD_OFS, 32'h0);
        chk(rd[7:0], 8'h99);
        bus(1'b1, STAT_OFS, 32'h0000_0010);
        bus(1'b0, STAT_OFS, 32'h0);
        chk(rd[4:0], 5'b00100);
        $display("FIFO fill and drain done");
    endtask

    task automatic slave;
        logic [7:0] got;
        int         k;
        logic [7:0] din_v;
        din_v = 8'h5a;
        bus(1'b1, CTRL_OFS, 32'h0000_040d);
        bus(1'b0, STAT_OFS, 32'h0);
        chk(rd, 32'h0001_7004);
        chk({po.sclk_oe, po.fsx_oe}, 2'b00);
        bus(1'b1, TXD_OFS, 32'h0000_0096);
        @(posedge clk_sys);
        t_fsx <= 1'b0;
        k = 0;
        while (po.dout_oe !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            k++;
        end
        chk(k >= 3 && k <= 8, 1'b1);
        for (int i = 7; i >= 0; i--) begin
            t_sclk <= 1'b1;
            t_din <= din_v[i];
            repeat (2) @(posedge clk_sys);
            got = {got[6:0], po.dout};
            t_sclk <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
        t_fsx <= 1'b1;
        t_din <= ~t_din;
        k = 0;
        while (po.dout_oe !== 1'b0 && k < 20) begin
            @(posedge clk_sys);
            k++;
        end
        chk(k >= 2 && k <= 6, 1'b1);
        chk(got, 8'h96);
        bus(1'b0, RXD_OFS, 32'h0);
        chk(rd[7:0], din_v);
        $display("Slave frame done");
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        bus(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h0000_0100);
        bus(1'b1, 5'h10, 32'hffff_ffff);
        bus(1'b0, 5'h10, 32'h0);
        chk(rd, 32'h0);
        $display("Reset and map done");
        frame(2'b11, 1'b0, 8'h01, 8'ha5, 8'h3c);
        frame(2'b10, 1'b1, 8'h02, 8'h81, 8'h7e);
        frame(2'b11, 1'b0, 8'h04, 8'h5b, 8'hc6);
        frame(2'b10, 1'b0, 8'h03, 8'h3c, 8'h99);
        fill_drain();
        slave();
        conclude();
    end
endmodule
